/* File: spg_consts.vh */
// constants for the stepper phase gate and fault latch block
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus
`ifndef SPG_CONSTS_VH
`define SPG_CONSTS_VH

// core clock period in ns
`define SPG_CLK_NS 10
// overcurrent blanking after each chopping turn-on, in ns
`define SPG_BLANK_NS 5500
// blanking length in clock cycles
`define SPG_BLANK_CYC (`SPG_BLANK_NS / `SPG_CLK_NS)
`define SPG_BLANK_W 10
// counter reload, one less than the window since the turn-on edge counts
`define SPG_BLANK_LOAD 10'h225

// register byte offsets
`define SPG_OFF_CTRL 4'h0
`define SPG_OFF_STATUS 4'h4
`define SPG_OFF_IRQ_STAT 4'h8
`define SPG_OFF_IRQ_MASK 4'hC

// control register fields
`define SPG_CTRL_DRIVE_EN 0
`define SPG_CTRL_RESET 8'h01

// status register fields
`define SPG_ST_OC 0
`define SPG_ST_OT 1
`define SPG_ST_BLANK 2
`define SPG_ST_WIND_LO 4

// interrupt event bits, same layout in mask
`define SPG_EV_OC 0
`define SPG_EV_OT 1
`define SPG_EV_CLASH 2
`define SPG_EV_W 3
`define SPG_MASK_RESET 3'h0

// AXI responses
`define SPG_RESP_OKAY 2'h0
`define SPG_RESP_SLVERR 2'h2

`endif

/* File: spg_blank.v */
// overcurrent blanking timer
// assumes chop_on_i is a synchronous level, high while the chopper conducts
`timescale 1ns/1ns
`include "spg_consts.vh"

module spg_blank
(
  // clock and reset
  input wire mclk_i,
  input wire reset_n_i,
  input wire sys_clear_n_i,
  // chopper state
  input wire chop_on_i,
  // blanking window
  output wire blank_o
);

  reg chop_prev_q;
  reg [`SPG_BLANK_W-1:0] cnt_q;
  reg [`SPG_BLANK_W-1:0] cnt_d;
  wire rise;

  assign rise = chop_on_i & ~chop_prev_q;
  // (RULE9) blanking after turn-on
  assign blank_o = rise | (cnt_q != {`SPG_BLANK_W{1'b0}});

  always @*
  begin
    cnt_d = cnt_q;
    if (!sys_clear_n_i)
      cnt_d = {`SPG_BLANK_W{1'b0}};
    else if (rise)
      cnt_d = `SPG_BLANK_LOAD;
    else if (cnt_q != {`SPG_BLANK_W{1'b0}})
      cnt_d = cnt_q - 1'b1;
  end

  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      chop_prev_q <= 1'b0;
      cnt_q <= {`SPG_BLANK_W{1'b0}};
    end
    else
    begin
      chop_prev_q <= chop_on_i;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: spg_top.v */
// phase gate, interlock, fault latch and register slave of a stepper driver
// assumes synchronous inputs, analog comparators for current and heat,
// and reset_n_i driven from the logic supply power-on detector
// How it works
// (RULE1) a low phase command turns its winding on when nothing blocks it.
// (RULE2) the two outputs of one winding are never on together.
// (RULE3) both commands of a pair low turns that whole winding off.
// (RULE4) a low system clear holds the logic in its reset state.
// (RULE5) a low enable forces all four windings off.
// (RULE6) the open-drain fault flag pulls low while a trip is latched.
// (RULE7) a trip latches and keeps the windings off until cleared.
// (RULE8) only power-on reset or a clear pulse releases the latch.
// (RULE9) overcurrent is ignored for 5.5 us after each chop turn-on.
// (RULE10) overcurrent at about 3.5 A trips after the blanking window.
// (RULE11) substrate overheat at about 144 C trips the latch.
// (RULE12) power-on reset below about 4 V clears all control state.
// (RULE13) the controller keeps enable low while the supply is below 4.75 V.
// (RULE14) the controller slows the phase sequence before stopping.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "spg_consts.vh"

module spg_top
(
  // clock and power-on reset
  input wire mclk_i,
  input wire reset_n_i,
  // phase commands, active low
  input wire coil1_fwd_cmd_n_i,
  input wire coil1_rev_cmd_n_i,
  input wire coil2_fwd_cmd_n_i,
  input wire coil2_rev_cmd_n_i,
  // system clear and output enable
  input wire sys_clear_n_i,
  input wire enable_i,
  // analog detectors and chopper
  input wire oc_over_i,
  input wire ot_over_i,
  input wire chop_on_i,
  // winding outputs, order coil1 fwd, coil1 rev, coil2 fwd, coil2 rev
  output wire [3:0] winding_o,
  // open-drain fault flag
  output wire fault_n_o,
  output wire fault_oe_o,
  // interrupt
  output wire irq_o,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // mapped register check, used by both read and write paths
  function spg_mapped;
    input [31:0] addr;
    begin
      spg_mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    end
  endfunction

  wire [3:0] cmd;
  wire [3:0] gated;
  wire [1:0] clash;
  wire blank;
  wire run;
  wire oc_trip;
  wire ot_trip;
  wire [`SPG_EV_W-1:0] events;

  reg [3:0] winding_q;
  reg oc_q;
  reg ot_q;
  reg oc_d;
  reg ot_d;
  reg fault_oe_q;
  reg fault_n_q;
  reg [7:0] ctrl_q;
  reg [`SPG_EV_W-1:0] irq_stat_q;
  reg [`SPG_EV_W-1:0] irq_stat_d;
  reg [`SPG_EV_W-1:0] irq_mask_q;
  reg irq_q;
  reg [1:0] clash_q;

  // bus state
  reg awready_q;
  reg wready_q;
  reg [3:0] awaddr_q;
  reg aw_ok_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_d;
  wire aw_hs;
  wire w_hs;
  wire ar_hs;
  wire do_write;
  wire rd_clear;

  // (RULE1) low command means on
  assign cmd = ~{coil2_rev_cmd_n_i, coil2_fwd_cmd_n_i,
                 coil1_rev_cmd_n_i, coil1_fwd_cmd_n_i};

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_pair
      // (RULE2) pair interlock
      // (RULE3) both asserted gives both off
      assign gated[2*p] = cmd[2*p] & ~cmd[2*p+1];
      assign gated[2*p+1] = cmd[2*p+1] & ~cmd[2*p];
      assign clash[p] = cmd[2*p] & cmd[2*p+1];
    end
  endgenerate

  spg_blank u_blank
  (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .sys_clear_n_i(sys_clear_n_i),
    .chop_on_i(chop_on_i),
    .blank_o(blank)
  );

  // (RULE10) overcurrent counts only outside blanking
  assign oc_trip = oc_over_i & ~blank;
  // (RULE11) overheat trips at any time
  assign ot_trip = ot_over_i;

  always @*
  begin
    oc_d = oc_q | oc_trip;
    ot_d = ot_q | ot_trip;
    // (RULE8) clear pulse releases the latch
    // (RULE4) clear held low keeps logic reset
    if (!sys_clear_n_i)
    begin
      oc_d = 1'b0;
      ot_d = 1'b0;
    end
  end

  // (RULE5) enable and software drive gate
  // (RULE7) latched trip blocks outputs
  assign run = sys_clear_n_i & enable_i & ctrl_q[`SPG_CTRL_DRIVE_EN] &
               ~oc_d & ~ot_d;

  assign events[`SPG_EV_OC] = oc_d & ~oc_q;
  assign events[`SPG_EV_OT] = ot_d & ~ot_q;
  assign events[`SPG_EV_CLASH] = sys_clear_n_i & (|(clash & ~clash_q));

  // (RULE12) power-on reset clears all state
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      winding_q <= 4'h0;
      oc_q <= 1'b0;
      ot_q <= 1'b0;
      fault_oe_q <= 1'b0;
      fault_n_q <= 1'b1;
      clash_q <= 2'h0;
    end
    else
    begin
      winding_q <= run ? gated : 4'h0;
      oc_q <= oc_d;
      ot_q <= ot_d;
      // (RULE6) fault flag pulls low
      fault_oe_q <= oc_d | ot_d;
      fault_n_q <= ~(oc_d | ot_d);
      clash_q <= clash;
    end
  end

  // bus handshakes
  assign aw_hs = s_axi_awvalid & awready_q;
  assign w_hs = s_axi_wvalid & wready_q;
  assign ar_hs = s_axi_arvalid & arready_q;
  assign do_write = ~awready_q & ~wready_q & ~bvalid_q;
  assign rd_clear = ar_hs & spg_mapped(s_axi_araddr) &
                    (s_axi_araddr[3:0] == `SPG_OFF_IRQ_STAT);

  // sticky events, set wins over read clear
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (rd_clear)
      irq_stat_d = {`SPG_EV_W{1'b0}};
    irq_stat_d = irq_stat_d | events;
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    case (s_axi_araddr[3:0])
      `SPG_OFF_CTRL: rdata_d[7:0] = ctrl_q;
      `SPG_OFF_STATUS:
      begin
        rdata_d[`SPG_ST_OC] = oc_q;
        rdata_d[`SPG_ST_OT] = ot_q;
        rdata_d[`SPG_ST_BLANK] = blank;
        rdata_d[`SPG_ST_WIND_LO+3:`SPG_ST_WIND_LO] = winding_q;
      end
      `SPG_OFF_IRQ_STAT: rdata_d[`SPG_EV_W-1:0] = irq_stat_q;
      `SPG_OFF_IRQ_MASK: rdata_d[`SPG_EV_W-1:0] = irq_mask_q;
      default: rdata_d = 32'h00000000;
    endcase
    if (!spg_mapped(s_axi_araddr))
      rdata_d = 32'h00000000;
  end

  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= 4'h0;
      aw_ok_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SPG_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SPG_RESP_OKAY;
      ctrl_q <= `SPG_CTRL_RESET;
      irq_stat_q <= {`SPG_EV_W{1'b0}};
      irq_mask_q <= `SPG_MASK_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_q);
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr[3:0];
        aw_ok_q <= spg_mapped(s_axi_awaddr);
      end
      if (w_hs)
      begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= aw_ok_q ? `SPG_RESP_OKAY : `SPG_RESP_SLVERR;
        if (aw_ok_q && wstrb_q[0])
        begin
          if (awaddr_q == `SPG_OFF_CTRL)
            ctrl_q <= wdata_q[7:0];
          if (awaddr_q == `SPG_OFF_IRQ_MASK)
            irq_mask_q <= wdata_q[`SPG_EV_W-1:0];
        end
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (ar_hs)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rdata_d;
        rresp_q <= spg_mapped(s_axi_araddr) ? `SPG_RESP_OKAY :
                   `SPG_RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign winding_o = winding_q;
  assign fault_n_o = fault_n_q;
  assign fault_oe_o = fault_oe_q;
  assign irq_o = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;

endmodule

/* File: spg_chk.sv */
// assertions on the spg_top ports
// assumes it is bound into spg_top, one clock domain
`timescale 1ns/1ns
module spg_chk
(
  // clock and resets
  input wire mclk_i,
  input wire reset_n_i,
  input wire sys_clear_n_i,
  // commands and detectors
  input wire coil1_fwd_cmd_n_i,
  input wire coil1_rev_cmd_n_i,
  input wire enable_i,
  input wire oc_over_i,
  input wire ot_over_i,
  input wire chop_on_i,
  // outputs
  input wire [3:0] winding_o,
  input wire fault_n_o,
  input wire fault_oe_o
);
  reg chop_q;
  reg [9:0] age_q;
  wire rise = chop_on_i & ~chop_q;
  wire ok = sys_clear_n_i & ~ot_over_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // edges since the last chop turn-on
  always @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      chop_q <= 1'b0;
      age_q <= 10'h3FF;
    end
    else
    begin
      chop_q <= chop_on_i;
      if (!sys_clear_n_i)
        age_q <= 10'h3FF;
      else if (rise)
        age_q <= 10'h000;
      else if (age_q != 10'h3FF)
        age_q <= age_q + 10'h001;
    end
  end
  property p_pair; !(&winding_o[1:0]) && !(&winding_o[3:2]); endproperty
  a_pair: assert property (p_pair) else $error("pair on together");
  property p_on; !coil1_fwd_cmd_n_i && coil1_rev_cmd_n_i && enable_i && ok
    && !oc_over_i && fault_n_o |=> winding_o[0]; endproperty
  a_on: assert property (p_on) else $error("winding not on");
  property p_clash; !coil1_fwd_cmd_n_i && !coil1_rev_cmd_n_i
    |=> winding_o[1:0] == 2'h0; endproperty
  a_clash: assert property (p_clash) else $error("clash drives");
  property p_cut; !enable_i |=> winding_o == 4'h0; endproperty
  a_cut: assert property (p_cut) else $error("cutoff ignored");
  property p_clr; !sys_clear_n_i |=> winding_o == 4'h0 && fault_n_o;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_flag; ot_over_i && sys_clear_n_i |=> !fault_n_o && fault_oe_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not pulled");
  property p_hold; !fault_n_o && sys_clear_n_i
    |=> !fault_n_o && winding_o == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_blank; $rose(chop_on_i) && fault_n_o ##0 ok[*8] |=> fault_n_o;
  endproperty
  a_blank: assert property (p_blank) else $error("trip in blanking");
  property p_trip; age_q >= 10'h225 && !rise && oc_over_i && sys_clear_n_i
    |=> !fault_n_o && winding_o == 4'h0; endproperty
  a_trip: assert property (p_trip) else $error("no oc trip");
  property p_rel; $rose(sys_clear_n_i) && !ot_over_i && !oc_over_i
    |=> fault_n_o; endproperty
  a_rel: assert property (p_rel) else $error("latch not released");
  c_trip: cover property (!fault_n_o);
  c_blank: cover property ($rose(chop_on_i));
  c_clash: cover property (!coil1_fwd_cmd_n_i && !coil1_rev_cmd_n_i);
endmodule
bind spg_top spg_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .sys_clear_n_i(sys_clear_n_i), .coil1_fwd_cmd_n_i(coil1_fwd_cmd_n_i),
  .coil1_rev_cmd_n_i(coil1_rev_cmd_n_i), .enable_i(enable_i),
  .oc_over_i(oc_over_i), .ot_over_i(ot_over_i), .chop_on_i(chop_on_i),
  .winding_o(winding_o), .fault_n_o(fault_n_o), .fault_oe_o(fault_oe_o));

/* File: spg_seq.sv */
// step sequencer model driving the phase lines and enable
// assumes the driver clock; pattern bit high means phase on
`timescale 1ns/1ns
module spg_seq
(
  // clock
  input wire mclk_i,
  // bench requests
  input wire [3:0] pat_i,
  input wire pwr_ok_i,
  input wire en_req_i,
  // lines to the driver
  output reg [3:0] cmd_n_o,
  output reg enable_o
);
  always @(posedge mclk_i)
  begin
    cmd_n_o <= ~pat_i;
    enable_o <= pwr_ok_i & en_req_i;
  end
endmodule

/* File: spg_top_tb_top.sv */
// bench for spg_top with sequencer model
// assumes the checker is bound from its own file
`timescale 1ns/1ns
module spg_top_tb_top;
  reg clk = 0, rst_n = 0, clr_n = 1, oc = 0, ot = 0, chop = 0;
  reg pok = 0, enq = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  reg [3:0] pat = 0;
  reg [31:0] a = 0, wd = 0, rd;
  reg [1:0] rsp;
  wire [3:0] cmd_n, wind;
  wire en, flt_n, flt_oe, irq, awr, wr, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  integer fails = 0, tests_run = 0;
  always #5 clk = ~clk;
  spg_seq u_seq (.mclk_i(clk), .pat_i(pat), .pwr_ok_i(pok), .en_req_i(enq),
    .cmd_n_o(cmd_n), .enable_o(en));
  spg_top u_dut (.mclk_i(clk), .reset_n_i(rst_n),
    .coil1_fwd_cmd_n_i(cmd_n[0]), .coil1_rev_cmd_n_i(cmd_n[1]),
    .coil2_fwd_cmd_n_i(cmd_n[2]), .coil2_rev_cmd_n_i(cmd_n[3]),
    .sys_clear_n_i(clr_n), .enable_i(en), .oc_over_i(oc), .ot_over_i(ot),
    .chop_on_i(chop), .winding_o(wind), .fault_n_o(flt_n),
    .fault_oe_o(flt_oe), .irq_o(irq), .s_axi_awaddr(a), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(a),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("unexpected %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // one write or read, held until taken
  task bus(input w, input [31:0] ad, input [31:0] d);
    integer n;
  begin
    n = 0;
    @(posedge clk);
    a <= ad;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    do
    begin
      @(posedge clk);
      n = n + 1;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (arr) arv <= 1'b0;
    end
    while ((w ? bv : rv) !== 1'b1 && n < 50);
    br <= 1'b0;
    rr <= 1'b0;
    rd = rdat;
    rsp = w ? bresp : rresp;
    if (n == 50) fails = fails + 1;
  end
  endtask
  task t_regs;
  begin
    bus(0, 32'h0, 0);
    chk(rd, 32'h1, "ctrl");
    bus(0, 32'hC, 0);
    chk(rd, 32'h0, "mask");
    bus(0, 32'h10, 0);
    chk({rd[29:0], rsp}, 32'h2, "unmap_rd");
    bus(1, 32'h14, 32'hFF);
    chk({30'h0, rsp}, 32'h2, "unmap_wr");
    $display("t_regs done");
  end
  endtask
  task t_phase;
    integer i;
    reg [3:0] e;
    reg [15:0] s;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge clk);
      pat <= i[3:0];
      e = i[3:0];
      if (e[1:0] == 2'h3) e[1:0] = 2'h0;
      if (e[3:2] == 2'h3) e[3:2] = 2'h0;
      repeat (3) @(posedge clk);
      chk({28'h0, wind}, {28'h0, e}, "winding");
    end
    bus(0, 32'h8, 0);
    chk(rd, 32'h4, "ev_clash");
    // full steps, dwell growing before the halt
    s = 16'h9A65;
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      e = s[4*i +: 4];
      pat <= e;
      repeat (3 + i) @(posedge clk);
      chk({28'h0, wind}, {28'h0, e}, "slowdown");
    end
    pat <= 4'h5;
    repeat (3) @(posedge clk);
    bus(0, 32'h4, 0);
    chk(rd, 32'h50, "status");
    $display("t_phase done");
  end
  endtask
  task t_cut;
  begin
    enq <= 1'b0;
    repeat (3) @(posedge clk);
    chk({28'h0, wind}, 32'h0, "cutoff");
    bus(1, 32'h0, 32'h0);
    bus(0, 32'h0, 0);
    chk(rd, 32'h0, "ctrl_rw");
    bus(1, 32'h0, 32'h1);
    enq <= 1'b1;
    repeat (3) @(posedge clk);
    chk({28'h0, wind}, 32'h5, "resume");
    // drive gate off with coil1 idle
    pat <= 4'h4;
    bus(1, 32'h0, 32'h0);
    repeat (3) @(posedge clk);
    chk({28'h0, wind}, 32'h0, "sw_off");
    bus(1, 32'h0, 32'h1);
    pat <= 4'h5;
    clr_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({28'h0, wind}, 32'h0, "clear");
    clr_n <= 1'b1;
    $display("t_cut done");
  end
  endtask
  task t_oc;
  begin
    bus(1, 32'hC, 32'h1);
    chop <= 1'b1;
    oc <= 1'b1;
    bus(0, 32'h4, 0);
    chk(rd, 32'h54, "blank_st");
    repeat (537) @(posedge clk);
    chk({31'h0, flt_n}, 32'h1, "blanked");
    repeat (20) @(posedge clk);
    chk({31'h0, flt_n}, 32'h0, "oc_trip");
    chk({30'h0, flt_oe, irq}, 32'h3, "oe_irq");
    oc <= 1'b0;
    chop <= 1'b0;
    repeat (20) @(posedge clk);
    chk({27'h0, flt_n, wind}, 32'h0, "latched");
    bus(0, 32'h4, 0);
    chk(rd, 32'h1, "st_oc");
    bus(0, 32'h8, 0);
    chk(rd, 32'h1, "ev_oc");
    bus(0, 32'h8, 0);
    chk({rd[30:0], irq}, 32'h0, "ev_clr");
    clr_n <= 1'b0;
    repeat (2) @(posedge clk);
    clr_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({26'h0, flt_oe, flt_n, wind}, 32'h15, "release");
    $display("t_oc done");
  end
  endtask
  task t_ot;
  begin
    ot <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, flt_n, irq}, 32'h0, "ot_trip");
    ot <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, flt_n}, 32'h0, "ot_held");
    bus(0, 32'h8, 0);
    chk(rd, 32'h2, "ev_ot");
    pok <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pok <= 1'b1;
    repeat (3) @(posedge clk);
    chk({27'h0, flt_n, wind}, 32'h15, "por");
    $display("t_ot done");
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d failures %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pok <= 1'b1;
    t_regs;
    t_phase;
    t_cut;
    t_oc;
    t_ot;
    end_of_test;
  end
endmodule
